/* adc_seq_pkg.sv */
// package: register map, field layout and state encoding of the sample step control
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, low bits of haddr)
  // ----------------------------------------------------------------
  localparam int unsigned OFS_W          = 8;
  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h08;
  localparam logic [7:0]  OFS_IRQ_CLEAR  = 8'h0c;
  localparam logic [7:0]  OFS_SEQ_STATUS = 8'h10;
  localparam logic [7:0]  OFS_SLOT_MUX   = 8'h40;
  localparam logic [7:0]  OFS_SEQ_CTL    = 8'h44;

  // ----------------------------------------------------------------
  // slot layout
  // ----------------------------------------------------------------
  localparam int unsigned SLOTS      = 8;
  localparam int unsigned SLOT_IDX_W = 3;
  localparam int unsigned NIBBLE_W   = 4;
  localparam int unsigned PIN_W      = 3;
  localparam int unsigned INPUT_W    = 4;
  localparam int unsigned POS_PAIR   = 0;
  localparam int unsigned POS_LAST   = 1;
  localparam int unsigned POS_IRQ    = 2;
  localparam int unsigned POS_SENSOR = 3;
  localparam logic [SLOT_IDX_W-1:0] FIRST_SLOT = 3'h0;
  localparam logic [SLOT_IDX_W-1:0] FINAL_SLOT = 3'h7;
  localparam logic [SLOT_IDX_W-1:0] SLOT_STEP  = 3'h1;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL_RESET       = 32'h0000_0000;
  localparam logic [31:0] MUX_RESET       = 32'h0000_0000;
  localparam logic [31:0] MUX_WRITE_MASK  = 32'h7777_7777;
  localparam logic [31:0] SLOT1_LAST_MASK = 32'h0000_0002;
  localparam int unsigned SINGLE_SLOT_SEQ = 3;

  // ----------------------------------------------------------------
  // control, interrupt and status bits
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ENABLE    = 0;
  localparam int unsigned CTRL_TRIGGER   = 1;
  localparam int unsigned IRQ_W          = 2;
  localparam int unsigned IRQ_SAMPLE     = 0;
  localparam int unsigned IRQ_SEQ_DONE   = 1;
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_SLOT_LSB  = 4;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
  localparam logic [2:0]  HSIZE_WORD     = 3'b010;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_ADVANCE = 3'b010,
    ST_CONVERT = 3'b100
  } step_state_e;

  // picks one slot's nibble out of a packed eight-slot word
  function automatic logic [NIBBLE_W-1:0] slotNibble(input logic [31:0] word,
                                                      input logic [SLOT_IDX_W-1:0] slot);
    slotNibble = word[slot*NIBBLE_W +: NIBBLE_W];
  endfunction : slotNibble

endpackage : adc_seq_pkg

/* slot_decode.sv */
// slot_decode: splits the control and input-select words into one slot's fields
`timescale 1ns/1ps
module slot_decode
  import adc_seq_pkg::*;
(
  // packed configuration
  input  wire logic [31:0]           ctlWord,
  input  wire logic [31:0]           muxWord,
  input  wire logic [SLOT_IDX_W-1:0] slot,
  // decoded fields
  output logic                       sensorSelect,
  output logic                       irqEnable,
  output logic                       lastFlag,
  output logic                       pairSelect,
  output logic [PIN_W-1:0]           inputSelect
);

  logic [NIBBLE_W-1:0] ctlNibble;
  logic [NIBBLE_W-1:0] muxNibble;

  always_comb begin
    ctlNibble    = slotNibble(ctlWord, slot);
    muxNibble    = slotNibble(muxWord, slot);
    sensorSelect = ctlNibble[POS_SENSOR];
    irqEnable    = ctlNibble[POS_IRQ];
    lastFlag     = ctlNibble[POS_LAST];
    pairSelect   = ctlNibble[POS_PAIR];
    inputSelect  = muxNibble[PIN_W-1:0];
  end

endmodule : slot_decode

/* adc_step_control.sv */
// adc_step_control: per-slot control registers and sample sequencer stepping
//
// Summary of operation
// - With the eighth slot's sensor select set the temperature sensor is converted, else the pin in its input field.
// - A slot with its interrupt enable set raises the raw sequence interrupt when its conversion ends.
// - The raw interrupt reaches the interrupt output only while its mask bit is set.
// - Several slots may enable interrupts and each one raises the raw interrupt again on completion.
// - The slot carrying the last flag ends the sequence, and any slot from first to eighth may do so.
// - Slots after the last-flagged one are never requested, whatever they hold.
// - On the single-slot sequencer three the first slot's last flag is fixed at one.
// - A slot with pair select set and sensor select clear converts inputs 2i and 2i+1 differentially for input field i.
// - The temperature sensor is always converted single ended.
// - The seventh slot's control bits act like the eighth slot's but for the seventh sample.
// - The sequence control register holds four bits per slot for eight slots, slot index rising upward.
// - Each slot has a three-bit input select field in a companion register.
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module adc_step_control
  import adc_seq_pkg::*;
#(
  parameter int unsigned SEQ_NUM = 0
)(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  // trigger from the trigger logic
  input  wire logic                  seqTrigger,
  // converter core and input multiplexer
  input  wire logic                  convDone,
  output logic                       convReq,
  output logic                       convSensor,
  output logic                       convDiff,
  output logic [INPUT_W-1:0]         convPosInput,
  output logic [INPUT_W-1:0]         convNegInput,
  output logic [SLOT_IDX_W-1:0]      convSlot,
  // interrupts
  output logic                       raw_seq_irq,
  output logic                       irqOut
);

  // ----------------------------------------------------------------
  // constants that depend on the sequencer number
  // ----------------------------------------------------------------
  localparam bit          SINGLE_SLOT = (SEQ_NUM == SINGLE_SLOT_SEQ);
  localparam logic [31:0] CTL_FORCED  = SINGLE_SLOT ? SLOT1_LAST_MASK : CTL_RESET;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]           sample_sequence_control;
  logic [31:0]           slot_input_select_register;
  logic                  seqEnable;
  logic [IRQ_W-1:0]      irqStatus;
  logic [IRQ_W-1:0]      irq_mask_register;
  step_state_e           state;
  step_state_e           next_state;
  logic [SLOT_IDX_W-1:0] slotIdx;
  logic                  dataWrite;
  logic [OFS_W-1:0]      dataAddr;
  logic                  addrValid;
  logic                  addrWordOk;
  logic                  swTrigger;
  logic                  startSeq;
  logic                  slotFinish;
  logic                  finalSlot;
  logic [IRQ_W-1:0]      irqSet;
  logic [IRQ_W-1:0]      irqClear;
  logic                  decSensor;
  logic                  decIrq;
  logic                  decLast;
  logic                  decPair;
  logic [PIN_W-1:0]      decPin;
  logic [31:0]           readValue;
  logic                  wrControl;
  logic                  wrIrqEnable;
  logic                  wrIrqClear;
  logic                  wrSlotMux;
  logic                  wrSeqCtl;
  logic                  readTake;
  logic                  seqBusy;
  logic                  pairMode;
  logic                  fieldLatch;
  logic                  slotAdvance;
  logic                  seqDone;

  // pair number i maps to inputs 2i and 2i+1
  function automatic logic [INPUT_W-1:0] pairInput(input logic [PIN_W-1:0] pair,
                                                   input logic odd);
    pairInput = {pair, odd};
  endfunction : pairInput

  function automatic bit isOffset(input logic [OFS_W-1:0] addr,
                                  input logic [OFS_W-1:0] ofs);
    isOffset = (addr == ofs);
  endfunction : isOffset

  // ----------------------------------------------------------------
  // ahb-lite address phase
  // ----------------------------------------------------------------
  assign addrValid  = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addrWordOk = (hsize == HSIZE_WORD);
  assign readTake   = addrValid && !hwrite;

  // the slave never stretches a transfer and never signals an error
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dataWrite <= 1'b0;
      dataAddr  <= '0;
    end else begin
      dataWrite <= addrValid && hwrite && addrWordOk;
      dataAddr  <= haddr[OFS_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // write strobes, one per writable offset, all in the data phase
  // ----------------------------------------------------------------
  always_comb begin
    wrControl   = dataWrite && isOffset(dataAddr, OFS_CONTROL);
    wrIrqEnable = dataWrite && isOffset(dataAddr, OFS_IRQ_ENABLE);
    wrIrqClear  = dataWrite && isOffset(dataAddr, OFS_IRQ_CLEAR);
    wrSlotMux   = dataWrite && isOffset(dataAddr, OFS_SLOT_MUX);
    wrSeqCtl    = dataWrite && isOffset(dataAddr, OFS_SEQ_CTL);
  end

  // read data is captured at the address phase so it stands in the data phase
  always_comb begin
    readValue = '0;
    unique case (haddr[OFS_W-1:0])
      OFS_CONTROL:    readValue[CTRL_ENABLE] = seqEnable;
      OFS_IRQ_STATUS: readValue[IRQ_W-1:0] = irqStatus;
      OFS_IRQ_ENABLE: readValue[IRQ_W-1:0] = irq_mask_register;
      OFS_IRQ_CLEAR:  readValue = '0;
      OFS_SEQ_STATUS: begin
        readValue[STAT_BUSY] = seqBusy;
        readValue[STAT_SLOT_LSB +: SLOT_IDX_W] = slotIdx;
      end
      OFS_SLOT_MUX:   readValue = slot_input_select_register;
      OFS_SEQ_CTL:    readValue = sample_sequence_control;
      default:        readValue = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= '0;
    end else if (readTake) begin
      hrdata <= readValue;
    end
  end

  // ----------------------------------------------------------------
  // slot configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sample_sequence_control <= CTL_RESET | CTL_FORCED;
    end else if (wrSeqCtl) begin
      sample_sequence_control <= hwdata | CTL_FORCED;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slot_input_select_register <= MUX_RESET;
    end else if (wrSlotMux) begin
      slot_input_select_register <= hwdata & MUX_WRITE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seqEnable <= 1'b0;
    end else if (wrControl) begin
      seqEnable <= hwdata[CTRL_ENABLE];
    end
  end

  // trigger bit is a pulse, it never stores
  assign swTrigger = wrControl && hwdata[CTRL_TRIGGER];

  // ----------------------------------------------------------------
  // decode of the current slot
  // ----------------------------------------------------------------
  slot_decode u_slot_decode (
    .ctlWord      (sample_sequence_control),
    .muxWord      (slot_input_select_register),
    .slot         (slotIdx),
    .sensorSelect (decSensor),
    .irqEnable    (decIrq),
    .lastFlag     (decLast),
    .pairSelect   (decPair),
    .inputSelect  (decPin)
  );

  // a sequence ends on the last flag, on the top slot, or at once on the single-slot sequencer
  always_comb begin
    finalSlot = decLast;
    if (slotIdx == FINAL_SLOT) begin
      finalSlot = 1'b1;
    end
    if (SINGLE_SLOT) begin
      finalSlot = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer state machine
  // ----------------------------------------------------------------
  assign startSeq   = (state == ST_IDLE) && seqEnable && (seqTrigger || swTrigger);
  assign slotFinish = (state == ST_CONVERT) && convDone;

  // no wraparound: the top slot never advances
  assign slotAdvance = slotFinish && !finalSlot;
  assign seqDone     = slotFinish && finalSlot;
  assign seqBusy     = (state != ST_IDLE);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (startSeq) begin
          next_state = ST_ADVANCE;
        end
      end
      ST_ADVANCE: begin
        next_state = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (slotFinish) begin
          next_state = finalSlot ? ST_IDLE : ST_ADVANCE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slotIdx <= FIRST_SLOT;
    end else if (startSeq) begin
      slotIdx <= FIRST_SLOT;
    end else if (slotAdvance) begin
      slotIdx <= slotIdx + SLOT_STEP;
    end
  end

  // ----------------------------------------------------------------
  // converter and multiplexer outputs
  // ----------------------------------------------------------------
  assign convReq = (state == ST_CONVERT);

  // sensor select overrides pair select, the sensor has no pair
  assign pairMode   = decPair && !decSensor;
  assign fieldLatch = (state == ST_ADVANCE);

  // fields are latched while advancing so they are steady for the request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      convSensor <= 1'b0;
      convDiff   <= 1'b0;
      convSlot   <= FIRST_SLOT;
    end else if (fieldLatch) begin
      convSensor <= decSensor;
      convDiff   <= pairMode;
      convSlot   <= slotIdx;
    end
  end

  // input numbers for the multiplexer, a pair or a single pin
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      convPosInput <= '0;
      convNegInput <= '0;
    end else if (fieldLatch) begin
      if (pairMode) begin
        convPosInput <= pairInput(decPin, 1'b0);
        convNegInput <= pairInput(decPin, 1'b1);
      end else begin
        convPosInput <= {1'b0, decPin};
        convNegInput <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irqSet               = '0;
    irqSet[IRQ_SAMPLE]   = slotFinish && decIrq;
    irqSet[IRQ_SEQ_DONE] = seqDone;
  end

  always_comb begin
    irqClear = '0;
    if (wrIrqClear) begin
      irqClear = hwdata[IRQ_W-1:0];
    end
  end

  // a set arriving with its clear wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus <= '0;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqSet;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_register <= '0;
    end else if (wrIrqEnable) begin
      irq_mask_register <= hwdata[IRQ_W-1:0];
    end
  end

  assign raw_seq_irq = irqStatus[IRQ_SAMPLE];
  assign irqOut      = |(irqStatus & irq_mask_register);

endmodule : adc_step_control

/* adc_step_control_props.sv */
// checker: converter request, interrupt and bus answer properties
`timescale 1ns/1ps
module adc_step_control_chk
  import adc_seq_pkg::*;
#(
  parameter int unsigned SEQ_NUM = 0
)(
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  nrst,
  // bus answer
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  // converter link
  input wire logic                  convDone,
  input wire logic                  convReq,
  input wire logic                  convSensor,
  input wire logic                  convDiff,
  input wire logic [INPUT_W-1:0]    convPosInput,
  input wire logic [INPUT_W-1:0]    convNegInput,
  input wire logic [SLOT_IDX_W-1:0] convSlot,
  // interrupt
  input wire logic                  raw_seq_irq
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence sDone; convReq && convDone; endsequence
  sequence sIdle2; !convReq ##1 !convReq; endsequence

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_req_holds: assert property (convReq && !convDone |=> convReq && $stable({convSlot, convSensor,
    convDiff, convPosInput, convNegInput})) else $error("request changed before done");
  chk_req_drops: assert property (sDone |=> !convReq)
    else $error("request stayed after done");
  chk_next_slot: assert property (sDone ##1 !convReq ##1 convReq |-> convSlot == $past(convSlot, 2) + SLOT_STEP)
    else $error("next slot not one above");
  chk_first_slot: assert property (sIdle2 ##1 convReq |-> convSlot == FIRST_SLOT)
    else $error("sequence did not start at first slot");
  chk_sensor_single: assert property (convReq && convSensor |-> !convDiff)
    else $error("sensor converted differentially");
  chk_pair_inputs: assert property (convReq && convDiff |-> !convPosInput[0] && convNegInput == convPosInput + 4'h1)
    else $error("pair inputs not 2i and 2i+1");
  chk_single_ended: assert property (convReq && !convDiff && !convSensor |-> convNegInput == 4'h0 && !convPosInput[3])
    else $error("single ended input out of range");
  chk_irq_cause: assert property ($rose(raw_seq_irq) |-> $past(convDone) && $past(convReq))
    else $error("raw interrupt without finished conversion");
  chk_single_slot: assert property (SEQ_NUM == SINGLE_SLOT_SEQ && convReq |-> convSlot == FIRST_SLOT)
    else $error("single slot sequencer went past first slot");
endmodule : adc_step_control_chk

bind adc_step_control adc_step_control_chk #(.SEQ_NUM(SEQ_NUM)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp), .convDone(convDone),
  .convReq(convReq), .convSensor(convSensor), .convDiff(convDiff), .convPosInput(convPosInput),
  .convNegInput(convNegInput), .convSlot(convSlot), .raw_seq_irq(raw_seq_irq));

/* adc_conv_model.sv */
// converter core model: answers each request after a set number of cycles
`timescale 1ns/1ps
module adc_conv_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // request and answer
  input  wire logic       convReq,
  input  wire logic [3:0] lat,
  output logic            convDone
);
  logic [3:0] cnt;

  // one done pulse per request, lat+1 cycles after it rises
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt      <= 4'h0;
      convDone <= 1'b0;
    end else if (convDone || !convReq) begin
      cnt      <= 4'h0;
      convDone <= 1'b0;
    end else if (cnt == lat) begin
      convDone <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : adc_conv_model

/* tb_adc_step_control.sv */
// testbench: register access, sequence stepping and interrupts
`timescale 1ns/1ps
module tb_adc_step_control import adc_seq_pkg::*;;
  logic                  core_clk = 1'b0;
  logic                  nrst = 1'b0;
  logic                  hsel = 1'b1;
  logic [31:0]           haddr = 32'h0;
  logic [1:0]            htrans = 2'h0;
  logic                  hwrite = 1'b0;
  logic [2:0]            hsize = 3'h0;
  logic [31:0]           hwdata = 32'h0;
  logic                  seqTrigger = 1'b0;
  logic [3:0]            lat = 4'h0;
  logic                  hready, hreadyout, hresp, convDone, convReq, convSensor, convDiff, raw_seq_irq, irqOut;
  logic [31:0]           hrdata, rd;
  logic [INPUT_W-1:0]    convPosInput, convNegInput;
  logic [SLOT_IDX_W-1:0] convSlot;
  logic [12:0]           got[$];
  int                    error_cnt = 0;
  int                    samples_checked = 0;
  logic [31:0]           hrdata3, rd3;
  logic                  convReq3, convDone3;
  logic [2:0]            sz = HSIZE_WORD;
  int                    n3 = 0;

  always #12.5 core_clk = ~core_clk;
  assign hready = hreadyout;

  adc_step_control dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .seqTrigger(seqTrigger), .convDone(convDone), .convReq(convReq), .convSensor(convSensor),
    .convDiff(convDiff), .convPosInput(convPosInput), .convNegInput(convNegInput), .convSlot(convSlot),
    .raw_seq_irq(raw_seq_irq), .irqOut(irqOut));
  adc_conv_model conv (.core_clk(core_clk), .nrst(nrst), .convReq(convReq), .lat(lat), .convDone(convDone));
  // single-slot sequencer on the same bus
  adc_step_control #(.SEQ_NUM(SINGLE_SLOT_SEQ)) dut_single (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(), .hrdata(hrdata3), .hresp(), .seqTrigger(seqTrigger), .convDone(convDone3), .convReq(convReq3),
    .convSensor(), .convDiff(), .convPosInput(), .convNegInput(), .convSlot(), .raw_seq_irq(), .irqOut());
  adc_conv_model conv_single (.core_clk(core_clk), .nrst(nrst), .convReq(convReq3), .lat(lat), .convDone(convDone3));

  // record every conversion at the edge that completes it
  always @(posedge core_clk)
    if (convReq === 1'b1 && convDone === 1'b1) got.push_back({convSlot, convSensor, convDiff, convPosInput, convNegInput});

  // conversions completed by the single-slot sequencer
  always @(posedge core_clk)
    if (convReq3 === 1'b1 && convDone3 === 1'b1) n3++;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task waitRdy;
    int n;
    n = 0;
    do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin error_cnt++; end_sim(); end
  endtask : waitRdy

  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
    rd3 = hrdata3;
  endtask : xfer

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // program slots, start, wait for idle and compare every request
  task runSeq(input logic [31:0] ctl, input logic [31:0] mux, input logic viaReg);
    int k, n, last, n3b;
    logic ie, d;
    logic [3:0] nb;
    logic [2:0] p;
    logic [12:0] e, m;
    xfer(1'b1, OFS_SLOT_MUX, mux);
    xfer(1'b1, OFS_SEQ_CTL, ctl);
    xfer(1'b1, OFS_IRQ_CLEAR, 32'h3);
    got.delete();
    n3b = n3;
    last = 7;
    for (k = 7; k >= 0; k--) if (ctl[4*k+1]) last = k;
    ie = 1'b0;
    for (k = 0; k <= last; k++) ie |= ctl[4*k+2];
    if (viaReg) xfer(1'b1, OFS_CONTROL, 32'h3);
    else begin seqTrigger <= 1'b1; @(posedge core_clk); seqTrigger <= 1'b0; end
    n = 0;
    do begin xfer(1'b0, OFS_SEQ_STATUS, 32'h0); n++; end while (rd[STAT_BUSY] !== 1'b0 && n < 100);
    if (rd[STAT_BUSY] !== 1'b0) begin error_cnt++; end_sim(); end
    check(32'(got.size()), 32'(last + 1));
    check(32'(n3 - n3b), 32'h1);
    for (k = 0; k <= last; k++) begin
      nb = ctl[4*k +: 4];
      p = mux[4*k +: 3];
      d = nb[0] & ~nb[3];
      e = {k[2:0], nb[3], d, d ? {p, 1'b0} : {1'b0, p}, d ? {p, 1'b1} : 4'h0};
      m = nb[3] ? 13'h1f00 : 13'h1fff;
      check({19'h0, got[k] & m}, {19'h0, e & m});
    end
    rdchk(OFS_IRQ_STATUS, {30'h0, 1'b1, ie});
    check({31'h0, irqOut}, {31'h0, ie});
  endtask : runSeq

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int L;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    check({31'h0, convReq}, 32'h0);
    rdchk(OFS_SEQ_CTL, CTL_RESET);
    check(rd3, SLOT1_LAST_MASK);
    rdchk(OFS_SLOT_MUX, MUX_RESET);
    xfer(1'b1, OFS_SEQ_CTL, 32'hffff_ffff);
    rdchk(OFS_SEQ_CTL, 32'hffff_ffff);
    xfer(1'b1, OFS_SLOT_MUX, 32'hffff_ffff);
    rdchk(OFS_SLOT_MUX, MUX_WRITE_MASK);
    sz = 3'h0;
    xfer(1'b1, OFS_SEQ_CTL, 32'h0);
    sz = HSIZE_WORD;
    rdchk(OFS_SEQ_CTL, 32'hffff_ffff);
    xfer(1'b1, OFS_SEQ_CTL, 32'h0);
    rdchk(OFS_SEQ_CTL, 32'h0);
    check(rd3, SLOT1_LAST_MASK);
    xfer(1'b1, 8'h30, 32'hffff_ffff);
    rdchk(8'h30, 32'h0);
    seqTrigger <= 1'b1;
    @(posedge core_clk);
    seqTrigger <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({31'h0, convReq}, 32'h0);
    xfer(1'b1, OFS_IRQ_ENABLE, 32'h1);
    xfer(1'b1, OFS_CONTROL, 32'h1);
    runSeq(32'hffff_6095, 32'h7654_3217, 1'b0);
    xfer(1'b1, OFS_IRQ_ENABLE, 32'h0);
    @(posedge core_clk);
    check({30'h0, raw_seq_irq, irqOut}, 32'h2);
    xfer(1'b1, OFS_IRQ_ENABLE, 32'h1);
    lat <= 4'h5;
    for (L = 0; L < 8; L++) runSeq(32'h8c00_0000 | (32'h2 << (4 * L)), 32'h0123_4567, L[0]);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_sim();
  end
endmodule : tb_adc_step_control
